// ### logic/bcce_pkg.sv
// constants and types for the branch, call and compare execute slice
package bcce_pkg;
	// first opcode bytes
	localparam logic [7:0] OP_BNV = 8'hF4;
	localparam logic [7:0] OP_BOV = 8'hF5;
	localparam logic [7:0] OP_BPL = 8'hF6;
	localparam logic [7:0] OP_BR = 8'hFE;
	localparam logic [7:0] OP_CALL_REL = 8'hC5;
	localparam logic [7:0] OP_CALL_IND = 8'hC6;
	localparam logic [7:0] OP_BIT_CLEAR = 8'h08;
	// size bit sits in bit 3 of the first byte; these are the other seven bits
	localparam logic [3:0] OP_CMP_HI = 4'h4;
	localparam logic [3:0] OP_CJD_HI = 4'hE;
	localparam logic [3:0] OP_CJI_HI = 4'h9;
	localparam logic [2:0] OP_CJD_LO = 3'h2;
	localparam logic [2:0] OP_CJI_LO = 3'h3;
	localparam int SIZE_BIT = 3;
	// compare addressing modes in the low three opcode bits
	localparam logic [2:0] CM_RR = 3'h1;
	localparam logic [2:0] CM_IND = 3'h2;
	localparam logic [2:0] CM_OFF8 = 3'h4;
	localparam logic [2:0] CM_OFF16 = 3'h5;
	// flag vector positions
	localparam int FL_C = 4;
	localparam int FL_AC = 3;
	localparam int FL_V = 2;
	localparam int FL_N = 1;
	localparam int FL_Z = 0;
	localparam logic [4:0] FL_ALL = 5'h1F;
	localparam logic [4:0] FL_CNZ = 5'h13;
	// instruction lengths in bytes
	localparam logic [2:0] LEN_2 = 3'h2;
	localparam logic [2:0] LEN_3 = 3'h3;
	localparam logic [2:0] LEN_4 = 3'h4;
	localparam logic [2:0] LEN_5 = 3'h5;
	// clock counts
	localparam logic [3:0] CLK_BC_T = 4'h6;
	localparam logic [3:0] CLK_BC_NT = 4'h3;
	localparam logic [3:0] CLK_BR = 4'h6;
	localparam logic [3:0] CLK_CALLR = 4'h7;
	localparam logic [3:0] CLK_CALLR_PZ = 4'h4;
	localparam logic [3:0] CLK_CALLI = 4'h8;
	localparam logic [3:0] CLK_CALLI_PZ = 4'h5;
	localparam logic [3:0] CLK_CJD_T = 4'hA;
	localparam logic [3:0] CLK_CJD_NT = 4'h7;
	localparam logic [3:0] CLK_CJI_T = 4'h9;
	localparam logic [3:0] CLK_CJI_NT = 4'h6;
	localparam logic [3:0] CLK_CLR = 4'h4;
	localparam logic [3:0] CLK_CMP_RR = 4'h3;
	localparam logic [3:0] CLK_CMP_IND = 4'h4;
	localparam logic [3:0] CLK_CMP_OFF = 4'h6;
	localparam logic [3:0] CLK_BAD = 4'h1;
	// stack decrements and high-word push offset
	localparam logic [15:0] SP_DEC_FULL = 16'h0004;
	localparam logic [15:0] SP_DEC_PZ = 16'h0002;
	localparam logic [15:0] SP_HI_OFS = 16'h0002;
	typedef enum logic [3:0] {
		C_BCOND, C_BR, C_CALLR, C_CALLI, C_CJD, C_CJI, C_CLR, C_CMP, C_BAD
	} bcce_class_t;
	typedef enum logic {S_IDLE, S_RUN} bcce_state_t;
endpackage

// ### logic/bcce_exec.sv
// execute unit for short branches, calls, compare-and-jump, bit clear and compare
`timescale 1ns/1ps
`default_nettype none
module bcce_exec
	import bcce_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic [47:0] instBytes,
	input wire logic [23:0] pcIn,
	input wire logic [15:0] spIn,
	input wire logic [4:0] flagsIn,
	input wire logic page_zero_mode,
	input wire logic [7:0] write_segment,
	output logic [3:0] regAddr,
	input wire logic [15:0] regData,
	output logic memRd,
	output logic memWr,
	output logic memWordSize,
	output logic [23:0] memAddr,
	output logic [15:0] memWData,
	input wire logic [15:0] memRdData,
	output logic busy,
	output logic done,
	output logic badOp,
	output logic [23:0] pcOut,
	output logic spWrite,
	output logic [15:0] stack_pointer,
	output logic [4:0] flagsOut,
	output logic [4:0] flagsWrite
);
	bcce_state_t state_q;
	bcce_class_t cls_q;
	bcce_class_t clsD;
	logic [47:0] inst_q;
	logic [3:0] cnt_q;
	logic [3:0] endNt_q;
	logic [3:0] endT_q;
	logic [3:0] endNtD;
	logic [3:0] endTD;
	logic [2:0] len_q;
	logic [2:0] lenD;
	logic brTaken_q;
	logic [15:0] opA_q;
	logic [15:0] opB_q;
	logic [15:0] memVal_q;
	logic memPend_q;
	logic pz_q;
	logic [15:0] sp_q;
	logic [23:0] pc_q;
	logic [4:0] flIn_q;
	logic [7:0] b0;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] b3;
	logic [7:0] b4;
	logic sizeWord;
	logic [2:0] cmode;
	logic memDest;
	logic [15:0] memOp;
	logic [15:0] dstV;
	logic [15:0] srcV;
	logic [16:0] diff;
	logic [4:0] res;
	logic cjTaken;
	logic taken;
	logic finish;
	logic [23:0] nextPc;
	logic [23:0] brTarget;
	logic [15:0] offs;
	logic [15:0] spDec;

	assign b0 = inst_q[47:40];
	assign b1 = inst_q[39:32];
	assign b2 = inst_q[31:24];
	assign b3 = inst_q[23:16];
	assign b4 = inst_q[15:8];
	assign sizeWord = b0[SIZE_BIT];
	assign cmode = b0[2:0];
	assign memDest = b1[3];
	assign memOp = memPend_q ? memRdData : memVal_q;
	assign nextPc = pc_q + {21'h0, len_q};
	assign spDec = pz_q ? SP_DEC_PZ : SP_DEC_FULL;

	// decode of the first byte at request time
	always_comb
	begin
		clsD = C_BAD;
		lenD = LEN_2;
		endNtD = CLK_BAD - 4'h1;
		endTD = CLK_BAD - 4'h1;
		if (instBytes[47:40] == OP_BNV || instBytes[47:40] == OP_BOV || instBytes[47:40] == OP_BPL)
		begin
			clsD = C_BCOND;
			endNtD = CLK_BC_NT - 4'h1;
			endTD = CLK_BC_T - 4'h1;
		end
		else if (instBytes[47:40] == OP_BR)
		begin
			clsD = C_BR;
			endNtD = CLK_BR - 4'h1;
			endTD = CLK_BR - 4'h1;
		end
		else if (instBytes[47:40] == OP_CALL_REL)
		begin
			clsD = C_CALLR;
			lenD = LEN_3;
			endNtD = (page_zero_mode ? CLK_CALLR_PZ : CLK_CALLR) - 4'h1;
			endTD = endNtD;
		end
		else if (instBytes[47:40] == OP_CALL_IND)
		begin
			clsD = C_CALLI;
			endNtD = (page_zero_mode ? CLK_CALLI_PZ : CLK_CALLI) - 4'h1;
			endTD = endNtD;
		end
		else if (instBytes[47:40] == OP_BIT_CLEAR)
		begin
			clsD = C_CLR;
			lenD = LEN_3;
			endNtD = CLK_CLR - 4'h1;
			endTD = endNtD;
		end
		else if (instBytes[47:44] == OP_CJD_HI && instBytes[42:40] == OP_CJD_LO)
		begin
			clsD = C_CJD;
			lenD = LEN_4;
			endNtD = CLK_CJD_NT - 4'h1;
			endTD = CLK_CJD_T - 4'h1;
		end
		else if (instBytes[47:44] == OP_CJI_HI && instBytes[42:40] == OP_CJI_LO)
		begin
			clsD = C_CJI;
			lenD = instBytes[43] ? LEN_5 : LEN_4;
			endNtD = CLK_CJI_NT - 4'h1;
			endTD = CLK_CJI_T - 4'h1;
		end
		else if (instBytes[47:44] == OP_CMP_HI)
		begin
			clsD = C_CMP;
			unique case (instBytes[42:40])
				CM_RR:
				begin
					endNtD = CLK_CMP_RR - 4'h1;
				end
				CM_IND:
				begin
					endNtD = CLK_CMP_IND - 4'h1;
				end
				CM_OFF8:
				begin
					lenD = LEN_3;
					endNtD = CLK_CMP_OFF - 4'h1;
				end
				CM_OFF16:
				begin
					lenD = LEN_4;
					endNtD = CLK_CMP_OFF - 4'h1;
				end
				default:
				begin
					clsD = C_BAD;
					endNtD = CLK_BAD - 4'h1;
				end
			endcase
			endTD = endNtD;
		end
	end

	// memory operand offset
	always_comb
	begin
		offs = 16'h0000;
		if (cmode == CM_OFF8)
		begin
			offs = {{8{b2[7]}}, b2};
		end
		else if (cmode == CM_OFF16)
		begin
			offs = {b2, b3};
		end
	end

	// operand selection and subtraction
	always_comb
	begin
		dstV = opA_q;
		srcV = opB_q;
		if (cls_q == C_CJD)
		begin
			srcV = memOp;
		end
		else if (cls_q == C_CJI)
		begin
			srcV = sizeWord ? {b3, b4} : {8'h00, b3};
		end
		else if (cmode != CM_RR)
		begin
			dstV = memDest ? memOp : opA_q;
			srcV = memDest ? opA_q : memOp;
		end
		if (!sizeWord)
		begin
			dstV = {8'h00, dstV[7:0]};
			srcV = {8'h00, srcV[7:0]};
		end
	end

	// flags of dst - src, result itself never stored
	always_comb
	begin
		diff = {1'b0, dstV} - {1'b0, srcV};
		res = 5'h00;
		res[FL_AC] = dstV[3:0] < srcV[3:0];
		if (sizeWord)
		begin
			res[FL_C] = diff[16];
			res[FL_N] = diff[15];
			res[FL_Z] = diff[15:0] == 16'h0000;
			res[FL_V] = (dstV[15] ^ srcV[15]) & (dstV[15] ^ diff[15]);
		end
		else
		begin
			res[FL_C] = diff[8];
			res[FL_N] = diff[7];
			res[FL_Z] = diff[7:0] == 8'h00;
			res[FL_V] = (dstV[7] ^ srcV[7]) & (dstV[7] ^ diff[7]);
		end
	end

	assign cjTaken = !res[FL_Z];
	assign taken = (cls_q == C_CJD || cls_q == C_CJI) ? cjTaken : brTaken_q;
	assign finish = state_q == S_RUN && (cnt_q == endT_q || (cnt_q == endNt_q && !taken));

	// branch target: sign-extended displacement times two, register value for the indirect call, bit 0 forced low
	always_comb
	begin
		brTarget = nextPc;
		unique case (cls_q)
			C_CALLR: brTarget = nextPc + {{7{b1[7]}}, b1, b2, 1'b0};
			C_CALLI: brTarget = {nextPc[23:16], opA_q[15:1], 1'b0};
			C_CJD: brTarget = nextPc + {{15{b3[7]}}, b3, 1'b0};
			C_CJI: brTarget = nextPc + {{15{b2[7]}}, b2, 1'b0};
			default: brTarget = nextPc + {{15{b1[7]}}, b1, 1'b0};
		endcase
		brTarget[0] = 1'b0;
	end

	// sequencer
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= S_IDLE;
			cnt_q <= 4'h0;
		end
		else if (state_q == S_IDLE)
		begin
			cnt_q <= 4'h0;
			if (start)
			begin
				state_q <= S_RUN;
			end
		end
		else if (finish)
		begin
			state_q <= S_IDLE;
		end
		else
		begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// instruction context captured at the request
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cls_q <= C_BAD;
			inst_q <= 48'h0000_0000_0000;
			len_q <= LEN_2;
			endNt_q <= 4'h0;
			endT_q <= 4'h0;
			brTaken_q <= 1'b0;
			pz_q <= 1'b0;
			sp_q <= 16'h0000;
			pc_q <= 24'h00_0000;
			flIn_q <= 5'h00;
		end
		else if (state_q == S_IDLE && start)
		begin
			cls_q <= clsD;
			inst_q <= instBytes;
			len_q <= lenD;
			endNt_q <= endNtD;
			endT_q <= endTD;
			pz_q <= page_zero_mode;
			sp_q <= spIn;
			pc_q <= pcIn;
			flIn_q <= flagsIn;
			unique case (instBytes[47:40])
				OP_BNV: brTaken_q <= !flagsIn[FL_V];
				OP_BOV: brTaken_q <= flagsIn[FL_V];
				OP_BPL: brTaken_q <= !flagsIn[FL_N];
				default: brTaken_q <= 1'b1;
			endcase
		end
	end

	// register reads: first operand at the request, second after cycle 0
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			regAddr <= 4'h0;
			opA_q <= 16'h0000;
			opB_q <= 16'h0000;
		end
		else if (state_q == S_IDLE)
		begin
			regAddr <= instBytes[47:40] == OP_CALL_IND ? {1'b0, instBytes[34:32]} : instBytes[39:36];
		end
		else if (cnt_q == 4'h0)
		begin
			opA_q <= regData;
			regAddr <= cmode == CM_RR ? b1[3:0] : {1'b0, b1[2:0]};
		end
		else if (cnt_q == 4'h1)
		begin
			opB_q <= regData;
		end
	end

	// data memory port: operand reads, stack pushes, bit read-modify-write
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			memRd <= 1'b0;
			memWr <= 1'b0;
			memWordSize <= 1'b0;
			memAddr <= 24'h00_0000;
			memWData <= 16'h0000;
		end
		else
		begin
			memRd <= 1'b0;
			memWr <= 1'b0;
			if (state_q == S_RUN && cnt_q == 4'h0 && (cls_q == C_CALLR || cls_q == C_CALLI))
			begin
				memWr <= 1'b1;
				memWordSize <= 1'b1;
				memAddr <= {8'h00, sp_q - spDec};
				memWData <= nextPc[15:0];
			end
			else if (state_q == S_RUN && cnt_q == 4'h1 && (cls_q == C_CALLR || cls_q == C_CALLI) && !pz_q)
			begin
				memWr <= 1'b1;
				memWordSize <= 1'b1;
				memAddr <= {8'h00, sp_q - spDec + SP_HI_OFS};
				memWData <= {8'h00, nextPc[23:16]};
			end
			else if (state_q == S_RUN && cnt_q == 4'h0 && cls_q == C_CLR)
			begin
				memRd <= 1'b1;
				memWordSize <= 1'b0;
				memAddr <= {17'h0_0000, b1[1:0], b2[7:3]};
			end
			else if (state_q == S_RUN && cnt_q == 4'h2 && cls_q == C_CLR)
			begin
				memWr <= 1'b1;
				memWData <= {8'h00, memRdData[7:0] & ~(8'h01 << b2[2:0])};
			end
			else if (state_q == S_RUN && cnt_q == 4'h1 && cls_q == C_CJD)
			begin
				memRd <= 1'b1;
				memWordSize <= sizeWord;
				memAddr <= {13'h0000, b1[2:0], b2};
			end
			else if (state_q == S_RUN && cnt_q == 4'h1 && cls_q == C_CMP && cmode != CM_RR)
			begin
				memRd <= 1'b1;
				memWordSize <= sizeWord;
				memAddr <= {write_segment, regData + offs};
			end
		end
	end

	// read data arrive one cycle after the strobe
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			memPend_q <= 1'b0;
			memVal_q <= 16'h0000;
		end
		else
		begin
			memPend_q <= memRd;
			if (memPend_q)
			begin
				memVal_q <= memRdData;
			end
		end
	end

	// completion: program counter, stack pointer and flags handed back
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			busy <= 1'b0;
			done <= 1'b0;
			badOp <= 1'b0;
			pcOut <= 24'h00_0000;
			spWrite <= 1'b0;
			stack_pointer <= 16'h0000;
			flagsOut <= 5'h00;
			flagsWrite <= 5'h00;
		end
		else
		begin
			busy <= (state_q == S_IDLE && start) || (state_q == S_RUN && !finish);
			done <= finish;
			badOp <= finish && cls_q == C_BAD;
			spWrite <= finish && (cls_q == C_CALLR || cls_q == C_CALLI);
			flagsWrite <= 5'h00;
			if (finish)
			begin
				pcOut <= nextPc;
				flagsOut <= flIn_q;
				stack_pointer <= sp_q;
				unique case (cls_q)
					C_BCOND, C_BR:
					begin
						if (taken)
						begin
							pcOut <= brTarget;
						end
					end
					C_CALLR, C_CALLI:
					begin
						pcOut <= brTarget;
						stack_pointer <= sp_q - spDec;
					end
					C_CJD, C_CJI:
					begin
						if (taken)
						begin
							pcOut <= brTarget;
						end
						flagsWrite <= FL_CNZ;
						flagsOut <= (flIn_q & ~FL_CNZ) | (res & FL_CNZ);
					end
					C_CMP:
					begin
						flagsWrite <= FL_ALL;
						flagsOut <= res;
					end
					C_CLR, C_BAD:
					begin
						pcOut <= nextPc;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### verif/bcce_exec_assertions.sv
// assertion checker on the ports of the execute slice
`timescale 1ns/1ps
`default_nettype none
module bcce_exec_assertions
	import bcce_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic [47:0] instBytes,
	input wire logic [23:0] pcIn,
	input wire logic [15:0] spIn,
	input wire logic [4:0] flagsIn,
	input wire logic page_zero_mode,
	input wire logic busy,
	input wire logic done,
	input wire logic [23:0] pcOut,
	input wire logic spWrite,
	input wire logic [15:0] stack_pointer,
	input wire logic [4:0] flagsOut,
	input wire logic [4:0] flagsWrite
);
	logic [47:0] insQ;
	logic [23:0] pcQ;
	logic [15:0] spQ;
	logic [4:0] flQ;
	logic pzQ;
	logic [3:0] cntQ;
	logic [7:0] op;
	logic [23:0] nx;
	logic [23:0] bt;
	logic isCj;
	assign op = insQ[47:40];
	assign nx = pcQ + 24'h00_0002;
	assign bt = (nx + {{15{insQ[39]}}, insQ[39:32], 1'b0}) & 24'hFF_FFFE;
	assign isCj = (op[7:4] == OP_CJI_HI && op[2:0] == OP_CJI_LO) || (op[7:4] == OP_CJD_HI && op[2:0] == OP_CJD_LO);
	// snapshot of the accepted instruction
	always_ff @(posedge mclk)
	begin
		if (start && (!busy || done))
			{insQ, pcQ, spQ, flQ, pzQ} <= {instBytes, pcIn, spIn, flagsIn, page_zero_mode};
	end
	// cycles since the accepting edge
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			cntQ <= 4'h0;
		else if (start && (!busy || done))
			cntQ <= 4'h1;
		else if (cntQ != 4'hF)
			cntQ <= cntQ + 4'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_bnv_target: assert property (done && op == OP_BNV |-> pcOut == (flQ[FL_V] ? nx : bt))
		else $error("no-overflow branch target wrong");
	a_bov_target: assert property (done && op == OP_BOV |-> pcOut == (flQ[FL_V] ? bt : nx))
		else $error("overflow branch target wrong");
	a_bpl_flags: assert property (
		done && op == OP_BPL |-> flagsWrite == 5'h00 && pcOut == (flQ[FL_N] ? nx : bt))
		else $error("plus branch wrong");
	a_short_jump: assert property (done && op == OP_BR |-> cntQ == 4'h7 && pcOut == bt)
		else $error("short jump wrong");
	a_call_stack: assert property (
		done && op == OP_CALL_REL |-> spWrite && stack_pointer == spQ - (pzQ ? 16'h0002 : 16'h0004)
		&& cntQ == (pzQ ? 4'h5 : 4'h8))
		else $error("relative call stack wrong");
	a_compare_jump_unequal_flags: assert property (
		done && isCj |-> flagsWrite == FL_CNZ && flagsOut[FL_V] == flQ[FL_V] && flagsOut[FL_AC] == flQ[FL_AC])
		else $error("compare-and-jump flags wrong");
	a_cmp_pair: assert property (
		done && op[7:4] == OP_CMP_HI && op[2:0] == CM_RR |-> flagsWrite == FL_ALL && cntQ == 4'h4)
		else $error("register compare wrong");
	a_bit_clear: assert property (done && op == OP_BIT_CLEAR |-> flagsWrite == 5'h00 && cntQ == 4'h5)
		else $error("bit clear wrong");
endmodule
bind bcce_exec bcce_exec_assertions chk (.*);
`default_nettype wire

// ### verif/bcce_mem_model.sv
// register file and data memory seen by the execute slice
`timescale 1ns/1ps
`default_nettype none
module bcce_mem_model (
	input wire logic mclk,
	input wire logic [3:0] regAddr,
	output logic [15:0] regData,
	input wire logic memRd,
	input wire logic memWr,
	input wire logic memWordSize,
	input wire logic [23:0] memAddr,
	input wire logic [15:0] memWData,
	output logic [15:0] memRdData
);
	logic [15:0] regs [16];
	logic [7:0] mb [512];
	logic [23:0] wrA [8];
	logic [15:0] wrD [8];
	logic [23:0] rdA;
	logic [15:0] rdQ = 16'h5A5A;
	int wrN = 0;
	assign regData = regs[regAddr];
	// read data stand one cycle only, then the bus toggles
	assign memRdData = rdQ;
	always @(posedge mclk)
	begin
		rdQ <= ~rdQ;
		if (memRd)
		begin
			rdA <= memAddr;
			rdQ <= memWordSize ? {mb[{memAddr[8:1], 1'b1}], mb[{memAddr[8:1], 1'b0}]} : {~rdQ[15:8], mb[memAddr[8:0]]};
		end
		if (memWr)
		begin
			wrA[wrN % 8] <= memAddr;
			wrD[wrN % 8] <= memWData;
			wrN <= wrN + 1;
		end
	end
endmodule
`default_nettype wire

// ### verif/test_branch_call_compare_exec.sv
// self-checking bench for the execute slice
`timescale 1ns/1ps
`default_nettype none
module test_branch_call_compare_exec
	import bcce_pkg::*;
;
	logic mclk, rst, start, page_zero_mode, memRd, memWr, memWordSize, busy, done, badOp, spWrite, sz, tk;
	logic [47:0] instBytes;
	logic [23:0] pcIn, pcOut, memAddr, ret;
	logic [15:0] spIn, regData, memWData, memRdData, stack_pointer, d16, a, b;
	logic [10:0] ad;
	logic [7:0] write_segment, op, d8;
	logic [4:0] flagsIn, flagsOut, flagsWrite, f;
	logic [3:0] regAddr, d, s;
	logic [7:0] brOps [4] = '{OP_BNV, OP_BOV, OP_BPL, OP_BR};
	int cyc, wrBase, errTotal = 0, checks = 0;
	bcce_exec dut (.*);
	bcce_mem_model mdl (.*);
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] want);
	begin
		checks++;
		if (seen !== want)
		begin
			errTotal++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
		end
	end
	endtask
	task automatic printVerdict;
	begin
		$display("checks %0d, mismatches %0d", checks, errTotal);
		if (errTotal == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	function automatic logic [4:0] subFl(input logic [15:0] x, input logic [15:0] y, input logic w);
		logic [16:0] r;
		int m;
		m = w ? 15 : 7;
		r = {1'b0, w ? x : {8'h00, x[7:0]}} - {1'b0, w ? y : {8'h00, y[7:0]}};
		return {r[m + 1], x[3:0] < y[3:0], x[m] != y[m] && r[m] != x[m], r[m], (w ? r[15:0] : {8'h00, r[7:0]}) == 16'h0000};
	endfunction
	function automatic logic [23:0] tgt(input logic [23:0] nx, input logic [15:0] dd);
		return (nx + {{7{dd[15]}}, dd, 1'b0}) & 24'hFF_FFFE;
	endfunction
	function automatic logic [15:0] memVal(input logic [8:0] ma, input logic w);
		return w ? {mdl.mb[{ma[8:1], 1'b1}], mdl.mb[{ma[8:1], 1'b0}]} : {8'h00, mdl.mb[ma]};
	endfunction
	// one instruction with fresh random context; cyc ends as clock count plus one
	task automatic run(input logic [47:0] ins, input logic pz);
	begin
		@(posedge mclk);
		start <= 1'b1;
		instBytes <= ins;
		page_zero_mode <= pz;
		pcIn <= 24'($urandom);
		spIn <= 16'($urandom);
		flagsIn <= 5'($urandom);
		write_segment <= 8'($urandom);
		wrBase = mdl.wrN;
		#1;
		cyc = 0;
		while (cyc < 16 && done !== 1'b1)
		begin
			@(posedge mclk);
			start <= 1'b0;
			#1;
			cyc++;
		end
	end
	endtask
	task automatic push(input logic [23:0] rt, input logic pz);
	begin
		check(24'(mdl.wrN - wrBase), pz ? 24'h1 : 24'h2);
		check(mdl.wrA[wrBase % 8][15:0], 16'(spIn - (pz ? 16'h0002 : 16'h0004)));
		check(mdl.wrD[wrBase % 8], rt[15:0]);
		if (!pz)
		begin
			check(mdl.wrA[(wrBase + 1) % 8][15:0], 16'(spIn - 16'h0002));
			check(mdl.wrD[(wrBase + 1) % 8], {8'h00, rt[23:16]});
		end
	end
	endtask
	initial
	begin
		void'($urandom(84));
		{start, instBytes, pcIn, spIn, flagsIn, page_zero_mode, write_segment} = '0;
		rst = 1'b1;
		foreach (mdl.mb[k])
			mdl.mb[k] = 8'($urandom);
		foreach (mdl.regs[k])
			mdl.regs[k] = 16'($urandom);
		repeat (8) @(posedge mclk);
		check({busy, done, memRd, memWr, spWrite}, 5'h00);
		rst <= 1'b0;
		for (int i = 0; i < 24; i++)
		begin
			op = brOps[i % 4];
			d8 = i < 4 ? 8'h80 : i < 8 ? 8'h7F : 8'($urandom);
			run({op, d8, 32'h0000_0000}, 1'b0);
			tk = op == OP_BR || (op == OP_BPL ? !flagsIn[FL_N] : flagsIn[FL_V] == (op == OP_BOV));
			check(pcOut, tk ? tgt(pcIn + 24'h00_0002, {{8{d8[7]}}, d8}) : pcIn + 24'h00_0002);
			check({flagsWrite, cyc[3:0]}, {5'h00, tk ? 4'h7 : 4'h4});
		end
		for (int i = 0; i < 8; i++)
		begin
			d16 = i < 2 ? (i[0] ? 16'h7FFF : 16'h8000) : 16'($urandom);
			run({OP_CALL_REL, d16, 24'h00_0000}, i[0]);
			ret = pcIn + 24'h00_0003;
			check(pcOut, tgt(ret, d16));
			check({spWrite, stack_pointer}, {1'b1, spIn - (i[0] ? 16'h0002 : 16'h0004)});
			push(ret, i[0]);
			run({OP_CALL_IND, 5'h00, d16[2:0], 32'h0000_0000}, i[0]);
			ret = pcIn + 24'h00_0002;
			check(pcOut, {ret[23:16], mdl.regs[d16[2:0]][15:1], 1'b0});
			push(ret, i[0]);
		end
		for (int i = 0; i < 16; i++)
		begin
			sz = i[0];
			d = 4'($urandom);
			s = i < 4 ? d : 4'($urandom);
			d8 = 8'($urandom);
			run({OP_CMP_HI, sz, CM_RR, d, s, 32'h0000_0000}, 1'b0);
			check(flagsOut, subFl(mdl.regs[d], mdl.regs[s], sz));
			run({OP_CMP_HI, sz, i[1] ? (i[3] ? CM_OFF16 : CM_OFF8) : CM_IND, d, i[2], s[2:0], d8, ~d8, 16'h0000}, 1'b0);
			a = mdl.regs[s[2:0]] + (i[1] ? (i[3] ? {d8, ~d8} : {{8{d8[7]}}, d8}) : 16'h0000);
			b = memVal(a[8:0], sz);
			check(mdl.rdA[15:0], a);
			check(flagsOut, i[2] ? subFl(b, mdl.regs[d], sz) : subFl(mdl.regs[d], b, sz));
			check(cyc, i[1] ? 7 : 5);
			for (int j = 0; j < 2; j++)
			begin
				ad = 11'($urandom);
				b = j ? memVal(ad[8:0], sz) : i < 4 ? mdl.regs[d] : 16'($urandom);
				run(j ? {OP_CJD_HI, sz, OP_CJD_LO, d, 1'b0, ad, d8, 16'h0000}
					: {OP_CJI_HI, sz, OP_CJI_LO, d, 4'h0, d8, sz ? b : {b[7:0], 8'h00}, 8'h00}, 1'b0);
				f = subFl(mdl.regs[d], b, sz);
				tk = !f[FL_Z];
				ret = pcIn + (j || !sz ? 24'h00_0004 : 24'h00_0005);
				check(pcOut, tk ? tgt(ret, {{8{d8[7]}}, d8}) : ret);
				check(flagsOut, {f[4], flagsIn[3:2], f[1:0]});
				check(cyc, (tk ? 10 : 7) + j);
			end
		end
		for (int i = 0; i < 6; i++)
		begin
			ad = 11'($urandom);
			run({OP_BIT_CLEAR, 6'h00, ad[9:8], ad[7:0], 24'h00_0000}, 1'b0);
			check(mdl.wrA[wrBase % 8][6:0], ad[9:3]);
			check(mdl.wrD[wrBase % 8][7:0], mdl.mb[ad[9:3]] & ~(8'h01 << ad[2:0]));
			run(48'h0000_0000_0000, 1'b0);
			check({badOp, cyc[3:0], pcOut}, {5'h12, pcIn + 24'h00_0002});
		end
		printVerdict;
	end
	initial
	begin
		#400_000;
		errTotal++;
		printVerdict;
	end
endmodule
`default_nettype wire
